// >>> design/coa_arbiter.sv
// control ownership arbiter: merges eight command sources, tracks owners,
// applies masks and runs the 2-wire / 3-wire start logic
// assumes all source words and drive inputs are synchronous to CLK
`timescale 1ns/1ps
// Contract
// - accept commands from six serial devices, software word and option board together
// - reference and direction have one owner; other functions may have many
// - commanding source owns function; single-owner others ignored until owner releases
// - multi-owner start keeps running while any source still requests start
// - start and jog act on rising edge only, not level
// - requests left high after stopping block start and jog until all release
// - starts latched by default; two-wire select bits 1-7 make start maintained
// - 3-wire: momentary start sets run latch, stop clears it
// - a start edge counts only if all start inputs were low before
// - no start with stop open, enable open or fault; ready is state bit 0
// - 2-wire: both run inputs closed starts in last direction
// - 2-wire: run continues while any run input closed
// - opening the last closed 2-wire run input stops drive even if 3-wire started it
// - five read-only owner registers, two function bytes, one bit per source
// - owner byte placement per function across the five owner registers
// - source bit order: option board, serial 1-6, software word
// - stop is never masked; any source stops at any time
// - port mask gates all but stop; three masks gate direction/reference, start/jog, fault/reset
// - mask bit 0 disables, 1 enables the function for that source
// - all sources merge into one readable 16-bit combined command word
module coa_arbiter (
    input wire logic CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [15:0] OPT_CMD,
    input wire logic [95:0] SER_CMD,
    input wire logic STOP_CLOSED,
    input wire logic ENABLE_CLOSED,
    input wire logic FAULT,
    output logic RUN_READY,
    output logic RUNNING,
    output logic DIRECTION_REV,
    output logic JOGGING,
    output logic [15:0] COMBINED_CMD
);

    // one bit per source for a given command bit
    function automatic logic [7:0] coa_column(input logic [7:0][15:0] w, input int b);
        logic [7:0] col;
        col = 8'h00;
        for (int i = 0; i < coa_pkg::NSRC; i++) begin
            col[i] = w[i][b];
        end
        return col;
    endfunction

    // byte-lane write into a 16-bit register
    function automatic logic [15:0] coa_write16(input logic [15:0] old, input logic [31:0] d,
                                                input logic [3:0] sel);
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = d[7:0];
        end
        if (sel[1]) begin
            res[15:8] = d[15:8];
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers and state

    logic [15:0] port_control_mask_reg;
    logic [15:0] direction_reference_mask_reg;
    logic [15:0] start_jog_mask_reg;
    logic [15:0] fault_reset_mask_reg;
    logic [15:0] two_wire_start_select_reg;
    logic [15:0] sw_cmd_reg;
    logic [7:0] own_stop_reg;
    logic [7:0] own_start_reg;
    logic [7:0] own_jog1_reg;
    logic [7:0] own_jog2_reg;
    logic [7:0] own_clr_reg;
    logic [7:0] own_ramp_reg;
    logic [7:0] own_flux_reg;
    logic [7:0] own_trim_reg;
    logic [7:0] all_req_prev_reg;
    logic [7:0] run2_prev_reg;
    logic block_reg;
    logic block_next;
    logic running_next;
    logic jogging_next;
    logic dir_next;
    logic [15:0] combined_next;

    ////////////////////////////////////////////////////////////////////////
    // source words gathered into one array in source order

    logic [7:0][15:0] src_cmd;

    assign src_cmd[coa_pkg::SRC_OPT] = OPT_CMD;
    assign src_cmd[coa_pkg::SRC_SW] = sw_cmd_reg;
    generate
        for (genvar g = coa_pkg::SER_FIRST; g <= coa_pkg::SER_LAST; g++) begin : g_ser
            assign src_cmd[g] = SER_CMD[(g - 1) * coa_pkg::CMD_W +: coa_pkg::CMD_W];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // masked requests per function; a 0 mask bit silences that source

    logic [7:0] port_en;
    logic [7:0] req_stop;
    logic [7:0] req_start;
    logic [7:0] req_jog1;
    logic [7:0] req_jog2;
    logic [7:0] req_dir;
    logic [7:0] req_ref;
    logic [7:0] req_clr;
    logic [7:0] req_reset;
    logic [7:0] req_ramp;
    logic [7:0] req_flux;
    logic [7:0] req_trim;
    logic [7:0] col_fwd;
    logic [7:0] col_rev;

    assign port_en = port_control_mask_reg[7:0];
    assign col_fwd = coa_column(src_cmd, coa_pkg::CMD_FWD);
    assign col_rev = coa_column(src_cmd, coa_pkg::CMD_REV);
    // stop bits bypass every mask so any source can halt the drive
    assign req_stop = coa_column(src_cmd, coa_pkg::CMD_STOP)
                    | coa_column(src_cmd, coa_pkg::CMD_CLIM_STOP)
                    | coa_column(src_cmd, coa_pkg::CMD_COAST);
    assign req_start = coa_column(src_cmd, coa_pkg::CMD_START) & port_en
                     & start_jog_mask_reg[15:8];
    assign req_jog1 = coa_column(src_cmd, coa_pkg::CMD_JOG1) & port_en
                    & start_jog_mask_reg[7:0];
    assign req_jog2 = coa_column(src_cmd, coa_pkg::CMD_JOG2) & port_en
                    & start_jog_mask_reg[7:0];
    assign req_dir = (col_fwd | col_rev) & port_en
                   & direction_reference_mask_reg[15:8];
    assign req_ref = (coa_column(src_cmd, coa_pkg::CMD_REF_A)
                    | coa_column(src_cmd, coa_pkg::CMD_REF_B)
                    | coa_column(src_cmd, coa_pkg::CMD_REF_C)) & port_en
                   & direction_reference_mask_reg[7:0];
    assign req_clr = coa_column(src_cmd, coa_pkg::CMD_CLR_FAULT) & port_en
                   & fault_reset_mask_reg[15:8];
    assign req_reset = coa_column(src_cmd, coa_pkg::CMD_RESET) & port_en
                     & fault_reset_mask_reg[7:0];
    assign req_ramp = coa_column(src_cmd, coa_pkg::CMD_RAMP_DIS) & port_en;
    assign req_flux = coa_column(src_cmd, coa_pkg::CMD_FLUX) & port_en;
    assign req_trim = coa_column(src_cmd, coa_pkg::CMD_TRIM) & port_en;

    ////////////////////////////////////////////////////////////////////////
    // single-owner functions: direction and speed reference

    coa_own_if dir_own ();
    coa_own_if ref_own ();

    assign dir_own.req = req_dir;
    assign ref_own.req = req_ref;

    coa_single_owner u_dir_owner (
        .clk(CLK),
        .rst(RST),
        .own(dir_own)
    );

    coa_single_owner u_ref_owner (
        .clk(CLK),
        .rst(RST),
        .own(ref_own)
    );

    // only the owner's forward/reverse bits steer direction
    logic own_fwd;
    logic own_rev;

    assign own_fwd = |(dir_own.owner & col_fwd & req_dir);
    assign own_rev = |(dir_own.owner & col_rev & req_dir);
    // both or neither closed keeps the last direction
    assign dir_next = (own_fwd && !own_rev) ? 1'b0
                    : (own_rev && !own_fwd) ? 1'b1 : DIRECTION_REV;

    ////////////////////////////////////////////////////////////////////////
    // start logic: 2-wire run levels and 3-wire latched starts

    logic [7:0] two_wire;
    logic [7:0] run2;
    logic [7:0] start3;
    logic [7:0] start_lvl;
    logic [7:0] jog_lvl;
    logic [7:0] all_req;
    logic rise_ok;
    logic start_event;
    logic jog_event;
    logic ready;
    logic run2_drop;
    logic stop_fall;

    assign two_wire = two_wire_start_select_reg[7:0];
    // 2-wire sources run on forward/reverse levels, gated like start
    assign run2 = two_wire & (col_fwd | col_rev) & port_en
                & start_jog_mask_reg[15:8];
    assign start3 = ~two_wire & req_start;
    assign start_lvl = run2 | start3;
    assign jog_lvl = req_jog1 | req_jog2;
    assign all_req = start_lvl | jog_lvl;
    // an edge only counts from an all-low state and outside the lockout
    assign rise_ok = (all_req_prev_reg == 8'h00) && !block_reg;
    assign start_event = rise_ok && (|start_lvl);
    assign jog_event = rise_ok && (|jog_lvl) && !RUNNING;
    assign ready = STOP_CLOSED && ENABLE_CLOSED && !FAULT && !(|req_stop);
    // last closed 2-wire run input opening stops even a 3-wire start
    assign run2_drop = (|run2_prev_reg) && !(|run2);

    // run latch: stop wins, then a 2-wire release, then a fresh start
    assign running_next = (!ready || run2_drop) ? 1'b0
                        : start_event ? 1'b1 : RUNNING;
    // jog runs only while held
    assign jogging_next = (!ready || !(|jog_lvl)) ? 1'b0
                        : jog_event ? 1'b1 : JOGGING;
    assign stop_fall = (RUNNING || JOGGING) && !(running_next || jogging_next);
    // requests still up when motion stops lock out start and jog
    assign block_next = (stop_fall && (|all_req)) ? 1'b1
                      : (all_req == 8'h00) ? 1'b0 : block_reg;

    ////////////////////////////////////////////////////////////////////////
    // combined command word in the common bit layout

    always_comb begin
        combined_next = 16'h0000;
        combined_next[coa_pkg::CMD_STOP] = |coa_column(src_cmd, coa_pkg::CMD_STOP);
        combined_next[coa_pkg::CMD_START] = |start_lvl;
        combined_next[coa_pkg::CMD_JOG1] = |req_jog1;
        combined_next[coa_pkg::CMD_CLR_FAULT] = |req_clr;
        combined_next[coa_pkg::CMD_FWD] = own_fwd;
        combined_next[coa_pkg::CMD_REV] = own_rev;
        combined_next[coa_pkg::CMD_JOG2] = |req_jog2;
        combined_next[coa_pkg::CMD_CLIM_STOP] = |coa_column(src_cmd, coa_pkg::CMD_CLIM_STOP);
        combined_next[coa_pkg::CMD_COAST] = |coa_column(src_cmd, coa_pkg::CMD_COAST);
        combined_next[coa_pkg::CMD_RAMP_DIS] = |req_ramp;
        combined_next[coa_pkg::CMD_FLUX] = |req_flux;
        combined_next[coa_pkg::CMD_TRIM] = |req_trim;
        // reference select comes from the single reference owner only
        combined_next[coa_pkg::CMD_REF_A] =
            |(ref_own.owner & coa_column(src_cmd, coa_pkg::CMD_REF_A) & req_ref);
        combined_next[coa_pkg::CMD_REF_B] =
            |(ref_own.owner & coa_column(src_cmd, coa_pkg::CMD_REF_B) & req_ref);
        combined_next[coa_pkg::CMD_REF_C] =
            |(ref_own.owner & coa_column(src_cmd, coa_pkg::CMD_REF_C) & req_ref);
        combined_next[coa_pkg::CMD_RESET] = |req_reset;
    end

    ////////////////////////////////////////////////////////////////////////
    // drive state, run latch and sampled request history

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RUNNING <= 1'b0;
            JOGGING <= 1'b0;
            DIRECTION_REV <= 1'b0;
            RUN_READY <= 1'b0;
            block_reg <= 1'b0;
            all_req_prev_reg <= 8'h00;
            run2_prev_reg <= 8'h00;
            COMBINED_CMD <= 16'h0000;
        end else begin
            RUNNING <= running_next;
            JOGGING <= jogging_next;
            DIRECTION_REV <= dir_next;
            RUN_READY <= ready;
            block_reg <= block_next;
            all_req_prev_reg <= all_req;
            run2_prev_reg <= run2;
            COMBINED_CMD <= combined_next;
        end
    end

    // multi-owner owner bytes: every commanding source is flagged
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            own_stop_reg <= 8'h00;
            own_start_reg <= 8'h00;
            own_jog1_reg <= 8'h00;
            own_jog2_reg <= 8'h00;
            own_clr_reg <= 8'h00;
            own_ramp_reg <= 8'h00;
            own_flux_reg <= 8'h00;
            own_trim_reg <= 8'h00;
        end else begin
            own_stop_reg <= req_stop;
            own_start_reg <= start_lvl;
            own_jog1_reg <= req_jog1;
            own_jog2_reg <= req_jog2;
            own_clr_reg <= req_clr;
            own_ramp_reg <= req_ramp;
            own_flux_reg <= req_flux;
            own_trim_reg <= req_trim;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait state, ack for one cycle, unmapped reads zero

    logic wb_req;
    logic wb_wr;
    logic hit_port;
    logic hit_dir_ref;
    logic hit_start_jog;
    logic hit_fault_rst;
    logic hit_two_wire;
    logic hit_sw_cmd;
    logic [15:0] rd_data;
    logic [15:0] drive_state;

    assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wb_wr = wb_req && WB_WE_I;
    assign hit_port = WB_ADR_I[7:2] == coa_pkg::ADR_PORT_MASK[7:2];
    assign hit_dir_ref = WB_ADR_I[7:2] == coa_pkg::ADR_DIR_REF_MASK[7:2];
    assign hit_start_jog = WB_ADR_I[7:2] == coa_pkg::ADR_START_JOG_MASK[7:2];
    assign hit_fault_rst = WB_ADR_I[7:2] == coa_pkg::ADR_FAULT_RST_MASK[7:2];
    assign hit_two_wire = WB_ADR_I[7:2] == coa_pkg::ADR_TWO_WIRE[7:2];
    assign hit_sw_cmd = WB_ADR_I[7:2] == coa_pkg::ADR_SW_CMD[7:2];

    always_comb begin
        drive_state = 16'h0000;
        drive_state[coa_pkg::ST_READY] = RUN_READY;
        drive_state[coa_pkg::ST_RUNNING] = RUNNING;
        drive_state[coa_pkg::ST_DIR_REV] = DIRECTION_REV;
        drive_state[coa_pkg::ST_JOGGING] = JOGGING;
        drive_state[coa_pkg::ST_BLOCKED] = block_reg;
    end

    // read mux; owner words pair low and high function bytes
    always_comb begin
        case (WB_ADR_I[7:2])
            coa_pkg::ADR_PORT_MASK[7:2]: rd_data = port_control_mask_reg;
            coa_pkg::ADR_DIR_REF_MASK[7:2]: rd_data = direction_reference_mask_reg;
            coa_pkg::ADR_START_JOG_MASK[7:2]: rd_data = start_jog_mask_reg;
            coa_pkg::ADR_FAULT_RST_MASK[7:2]: rd_data = fault_reset_mask_reg;
            coa_pkg::ADR_OWN_DIR_REF[7:2]: rd_data = {dir_own.owner, ref_own.owner};
            coa_pkg::ADR_OWN_START_STOP[7:2]: rd_data = {own_start_reg, own_stop_reg};
            coa_pkg::ADR_OWN_JOG[7:2]: rd_data = {own_jog1_reg, own_jog2_reg};
            coa_pkg::ADR_OWN_RAMP_CLR[7:2]: rd_data = {own_ramp_reg, own_clr_reg};
            coa_pkg::ADR_OWN_FLUX_TRIM[7:2]: rd_data = {own_flux_reg, own_trim_reg};
            coa_pkg::ADR_TWO_WIRE[7:2]: rd_data = two_wire_start_select_reg;
            coa_pkg::ADR_SW_CMD[7:2]: rd_data = sw_cmd_reg;
            coa_pkg::ADR_COMBINED[7:2]: rd_data = COMBINED_CMD;
            coa_pkg::ADR_DRIVE_STATE[7:2]: rd_data = drive_state;
            default: rd_data = 16'h0000;
        endcase
    end

    // bus handshake and read data; owner registers ignore writes
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= wb_req;
            WB_DAT_O <= wb_req ? {16'h0000, rd_data} : 32'h0000_0000;
        end
    end

    // writable registers; masks power up enabled so every source works
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            port_control_mask_reg <= coa_pkg::MASK_RESET;
            direction_reference_mask_reg <= coa_pkg::MASK_RESET;
            start_jog_mask_reg <= coa_pkg::MASK_RESET;
            fault_reset_mask_reg <= coa_pkg::MASK_RESET;
            two_wire_start_select_reg <= coa_pkg::TWO_WIRE_RESET;
            sw_cmd_reg <= coa_pkg::SW_CMD_RESET;
        end else if (wb_wr) begin
            if (hit_port) begin
                port_control_mask_reg <= coa_write16(port_control_mask_reg, WB_DAT_I, WB_SEL_I);
            end
            if (hit_dir_ref) begin
                direction_reference_mask_reg <=
                    coa_write16(direction_reference_mask_reg, WB_DAT_I, WB_SEL_I);
            end
            if (hit_start_jog) begin
                start_jog_mask_reg <= coa_write16(start_jog_mask_reg, WB_DAT_I, WB_SEL_I);
            end
            if (hit_fault_rst) begin
                fault_reset_mask_reg <= coa_write16(fault_reset_mask_reg, WB_DAT_I, WB_SEL_I);
            end
            // option board bit and upper byte cannot select 2-wire
            if (hit_two_wire) begin
                two_wire_start_select_reg <= coa_write16(two_wire_start_select_reg, WB_DAT_I,
                    WB_SEL_I) & coa_pkg::TWO_WIRE_VALID;
            end
            if (hit_sw_cmd) begin
                sw_cmd_reg <= coa_write16(sw_cmd_reg, WB_DAT_I, WB_SEL_I);
            end
        end
    end

endmodule

// >>> design/coa_pkg.sv
// constants shared by the control ownership arbiter and its self-checking bench
// assumes a 32-bit classic wishbone slave port with byte addresses
package coa_pkg;

    // source layout: option board, six serial devices, software word
    localparam int NSRC = 8;
    localparam int CMD_W = 16;
    localparam int SRC_OPT = 0;
    localparam int SRC_SW = 7;
    localparam int SER_FIRST = 1;
    localparam int SER_LAST = 6;

    // command word bit positions, shared by all sources and the combined word
    localparam int CMD_STOP = 0;
    localparam int CMD_START = 1;
    localparam int CMD_JOG1 = 2;
    localparam int CMD_CLR_FAULT = 3;
    localparam int CMD_FWD = 4;
    localparam int CMD_REV = 5;
    localparam int CMD_JOG2 = 6;
    localparam int CMD_CLIM_STOP = 7;
    localparam int CMD_COAST = 8;
    localparam int CMD_RAMP_DIS = 9;
    localparam int CMD_FLUX = 10;
    localparam int CMD_TRIM = 11;
    localparam int CMD_REF_A = 12;
    localparam int CMD_REF_B = 13;
    localparam int CMD_REF_C = 14;
    localparam int CMD_RESET = 15;

    // register byte offsets
    localparam logic [7:0] ADR_PORT_MASK = 8'h00;
    localparam logic [7:0] ADR_DIR_REF_MASK = 8'h04;
    localparam logic [7:0] ADR_START_JOG_MASK = 8'h08;
    localparam logic [7:0] ADR_FAULT_RST_MASK = 8'h0C;
    localparam logic [7:0] ADR_OWN_DIR_REF = 8'h10;
    localparam logic [7:0] ADR_OWN_START_STOP = 8'h14;
    localparam logic [7:0] ADR_OWN_JOG = 8'h18;
    localparam logic [7:0] ADR_OWN_RAMP_CLR = 8'h1C;
    localparam logic [7:0] ADR_OWN_FLUX_TRIM = 8'h20;
    localparam logic [7:0] ADR_TWO_WIRE = 8'h24;
    localparam logic [7:0] ADR_SW_CMD = 8'h28;
    localparam logic [7:0] ADR_COMBINED = 8'h2C;
    localparam logic [7:0] ADR_DRIVE_STATE = 8'h30;

    // reset values and writable bits
    localparam logic [15:0] MASK_RESET = 16'hFFFF;
    localparam logic [15:0] TWO_WIRE_RESET = 16'h0000;
    localparam logic [15:0] TWO_WIRE_VALID = 16'h00FE;
    localparam logic [15:0] SW_CMD_RESET = 16'h0000;

    // drive state word bits
    localparam int ST_READY = 0;
    localparam int ST_RUNNING = 1;
    localparam int ST_DIR_REV = 2;
    localparam int ST_JOGGING = 3;
    localparam int ST_BLOCKED = 4;

endpackage

// >>> design/coa_own_if.sv
// request and owner vectors between the arbiter and a single-owner tracker
// assumes one bit per source in the package's source order
`timescale 1ns/1ps
interface coa_own_if;
    logic [7:0] req;
    logic [7:0] owner;
    modport arb (input req, output owner);
    modport user (output req, input owner);
endinterface

// >>> design/coa_single_owner.sv
// one-owner tracker: a source keeps a function while it commands it
// assumes requests are already masked and synchronous to clk
`timescale 1ns/1ps
module coa_single_owner (
    input wire logic clk,
    input wire logic rst,
    coa_own_if.arb own
);

    logic [7:0] owner_reg;
    logic [7:0] owner_next;
    logic keep;
    logic [7:0] lowest;

    // the holder stays while it still asks; otherwise the lowest asking source wins
    assign keep = |(owner_reg & own.req);
    assign lowest = own.req & 8'(~own.req + 8'h01);
    assign owner_next = keep ? owner_reg : lowest;
    assign own.owner = owner_reg;

    ////////////////////////////////////////////////////////////////////////
    // owner register, empty after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            owner_reg <= 8'h00;
        end else begin
            owner_reg <= owner_next;
        end
    end

endmodule

// >>> test/coa_assertions.sv
// checker for the arbiter's bus answer and run outputs
// assumes it sees only the top module's ports, bound below
`timescale 1ns/1ps
module coa_assertions (
    input wire logic CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic [15:0] OPT_CMD,
    input wire logic [95:0] SER_CMD,
    input wire logic STOP_CLOSED,
    input wire logic ENABLE_CLOSED,
    input wire logic FAULT,
    input wire logic RUN_READY,
    input wire logic RUNNING,
    input wire logic [15:0] COMBINED_CMD
);
    // stop bits of the option board and serial devices; software word not visible here
    wire logic [6:0] stops = {SER_CMD[80], SER_CMD[64], SER_CMD[48], SER_CMD[32],
                              SER_CMD[16], SER_CMD[0], OPT_CMD[0]};
    wire logic stop_any = |stops;
    wire logic start_ok = STOP_CLOSED && ENABLE_CLOSED && !FAULT && !stop_any;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence bus_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    ack_follows_a: assert property (bus_req |=> WB_ACK_O) else $error("ack missing");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
    idle_data_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data idle");
    upper_zero_a: assert property (WB_DAT_O[31:16] == 16'h0) else $error("upper half set");
    ready_gate_a: assert property ((!STOP_CLOSED || !ENABLE_CLOSED || FAULT) |=> !RUN_READY)
        else $error("ready while blocked");
    stop_clears_a: assert property ((stop_any || !STOP_CLOSED) |=> !RUNNING)
        else $error("run kept after stop");
    start_gate_a: assert property ($rose(RUNNING) |-> $past(start_ok))
        else $error("bad start");
    combined_stop_a: assert property (stop_any |=> COMBINED_CMD[0])
        else $error("stop not merged");
endmodule
bind coa_arbiter coa_assertions u_coa_assertions (.CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .OPT_CMD(OPT_CMD),
    .SER_CMD(SER_CMD), .STOP_CLOSED(STOP_CLOSED), .ENABLE_CLOSED(ENABLE_CLOSED),
    .FAULT(FAULT), .RUN_READY(RUN_READY), .RUNNING(RUNNING), .COMBINED_CMD(COMBINED_CMD));

// >>> test/coa_src_model.sv
// stand-in for the option board and six serial command sources
// assumes the bench loads one source word per write strobe
`timescale 1ns/1ps
module coa_src_model (
    input wire logic clk,
    input wire logic [2:0] idx,
    input wire logic [15:0] word,
    input wire logic wr,
    output logic [15:0] opt,
    output logic [95:0] ser
);
    logic [15:0] src_reg [8] = '{default: 16'h0000};
    // each source holds its word until reloaded, all present at once
    always @(posedge clk) begin
        if (wr) src_reg[idx] <= word;
    end
    assign opt = src_reg[0];
    always_comb for (int n = 1; n < 7; n++) ser[(n - 1) * 16 +: 16] = src_reg[n];
endmodule

// >>> test/coa_arbiter_bench.sv
// self-checking bench for the control ownership arbiter
// assumes the source model drives the option board and serial words
`timescale 1ns/1ps
module coa_arbiter_bench;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, wr = 0, flt = 0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [2:0] idx = 3'h0, i, j;
    logic [15:0] word = 16'h0, opt, comb;
    logic [95:0] ser;
    logic [31:0] dout;
    logic ack, ready, run, jog, rev;
    int mismatches = 0, n_checks = 0, s;
    always #4 clk = ~clk;
    coa_arbiter u_coa_arbiter (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(dout),
        .WB_ACK_O(ack), .OPT_CMD(opt), .SER_CMD(ser), .STOP_CLOSED(1'b1),
        .ENABLE_CLOSED(1'b1), .FAULT(flt), .RUN_READY(ready), .RUNNING(run),
        .DIRECTION_REV(rev), .JOGGING(jog), .COMBINED_CMD(comb));
    coa_src_model u_coa_src_model (.clk(clk), .idx(idx), .word(word), .wr(wr), .opt(opt),
        .ser(ser));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] own_bit(input int n, input int hi);
        return 16'h0001 << (n + 8 * hi);
    endfunction
    // one classic cycle; hold until ack is sampled, bounded wait
    task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, 16'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rdat = dout;
        {cyc, stb} <= 2'b00;
        if (n >= 50) mismatches++;
    endtask
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string name);
        bus(a, 1'b0, 16'h0);
        check(name, exp, rdat[15:0]);
    endtask
    // load one source word, then let it settle through the arbiter
    task automatic src(input logic [2:0] n, input logic [15:0] w, input logic exp_run);
        @(posedge clk);
        {idx, word, wr} <= {n, w, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
        repeat (3) @(posedge clk);
        check("run", {15'h0, exp_run}, {15'h0, run});
    endtask
    task report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // watchdog far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        mismatches++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        s = $urandom(50785);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 4; a++) rd(8'(a * 4), 16'hFFFF, "mask");
        rd(coa_pkg::ADR_TWO_WIRE, 16'h0000, "two_wire");
        bus(coa_pkg::ADR_TWO_WIRE, 1'b1, 16'hFFFF);
        rd(coa_pkg::ADR_TWO_WIRE, 16'h00FE, "two_wire_wr");
        bus(coa_pkg::ADR_OWN_JOG, 1'b1, 16'hFFFF);
        rd(coa_pkg::ADR_OWN_JOG, 16'h0000, "owner_ro");
        rd(8'hFC, 16'h0000, "unmapped");
        bus(coa_pkg::ADR_TWO_WIRE, 1'b1, 16'h0000);
        i = 3'(1 + $urandom % 6);
        j = 3'(i % 6 + 1);
        // latched start, owner byte, stop with every port masked, no restart on level
        src(i, 16'h0002, 1'b1);
        rd(coa_pkg::ADR_OWN_START_STOP, own_bit(i, 1), "start_owner");
        bus(coa_pkg::ADR_PORT_MASK, 1'b1, 16'h0000);
        src(j, 16'h0001, 1'b0);
        rd(coa_pkg::ADR_OWN_START_STOP, own_bit(j, 0), "stop_owner");
        check("comb_stop", 16'h0001, {15'h0, comb[0]});
        bus(coa_pkg::ADR_PORT_MASK, 1'b1, 16'hFFFF);
        src(j, 16'h0000, 1'b0);
        src(i, 16'h0000, 1'b0);
        // start masked for one source, then fault refuses start
        bus(coa_pkg::ADR_START_JOG_MASK, 1'b1, 16'hFFFF & ~own_bit(i, 1));
        src(i, 16'h0002, 1'b0);
        src(i, 16'h0000, 1'b0);
        bus(coa_pkg::ADR_START_JOG_MASK, 1'b1, 16'hFFFF);
        flt <= 1'b1;
        src(i, 16'h0002, 1'b0);
        check("ready", 16'h0000, {15'h0, ready});
        src(i, 16'h0000, 1'b0);
        flt <= 1'b0;
        // two maintained sources: run while any is closed
        bus(coa_pkg::ADR_TWO_WIRE, 1'b1, own_bit(1, 0) | own_bit(2, 0));
        src(1, 16'h0010, 1'b1);
        src(2, 16'h0010, 1'b1);
        src(1, 16'h0000, 1'b1);
        src(2, 16'h0000, 1'b0);
        // latched start overridden by a maintained source closing then opening
        src(3, 16'h0002, 1'b1);
        src(3, 16'h0000, 1'b1);
        src(1, 16'h0010, 1'b1);
        src(1, 16'h0000, 1'b0);
        // software word jogs in reverse; direction needs its owner first
        bus(coa_pkg::ADR_SW_CMD, 1'b1, 16'h0024);
        rd(coa_pkg::ADR_COMBINED, 16'h0024, "comb_jog");
        rd(coa_pkg::ADR_DRIVE_STATE, 16'h000D, "state");
        check("jog_rev", 16'h0003, {14'h0, jog, rev});
        report_and_stop();
    end
endmodule
